/* File: pcc_regs.sv */
// register slice: priority and secure identification, per-partition capacity limit
module pcc_regs
    import pcc_pkg::*;
#(
    parameter int NUM_INST = 2,
    parameter int NUM_PART = 16,
    parameter int CAPACITY_WIDTH_FIELD = 16,
    parameter bit INST_SEL_PRESENT = 1'b1,
    parameter bit CAP_PART_PRESENT = 1'b1,
    parameter bit SECURE_MAP = 1'b1,
    parameter bit NARROWING = 1'b0,
    parameter logic [7:0] SECURE_PMG_LIMIT = 8'h0f,
    parameter logic [15:0] SECURE_PART_LIMIT = 16'h000f,
    // per-instance priority fields: has/zero-is-low flags and the two widths
    parameter logic [NUM_INST-1:0][5:0] INT_PRI_WD = '{default: 6'h04},
    parameter logic [NUM_INST-1:0][5:0] DS_PRI_WD = '{default: 6'h04},
    parameter logic [NUM_INST-1:0] INT_PRI_ZERO_LOW = '0,
    parameter logic [NUM_INST-1:0] DS_PRI_ZERO_LOW = '0,
    // secure page may show a differing internal width; equal means one shared view
    parameter logic [NUM_INST-1:0][5:0] INT_PRI_WD_SEC = INT_PRI_WD
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire pcc_pkg::pcc_reg_req_type req_i,
    input wire pcc_pkg::pcc_sel_type sel_sec_i,
    input wire pcc_pkg::pcc_sel_type sel_ns_i,
    input wire pcc_pkg::pcc_alloc_req_type alloc_i,
    output logic ack_o,
    output logic [31:0] rdata_o,
    output logic alloc_done_o,
    output logic alloc_allow_o
);
    import pcc_pkg::*;

    localparam int IW = (NUM_INST > 1) ? $clog2(NUM_INST) : 1;
    localparam int PW = (NUM_PART > 1) ? $clog2(NUM_PART) : 1;
    localparam int DEPTH = 2 * (1 << IW) * (1 << PW);
    localparam int AW = 1 + IW + PW;
    // implemented limit bits sit at the top of the field
    localparam logic [15:0] CAPACITY_LIMIT_FIELD_MASK = 16'(16'hffff << (PCC_CAPACITY_LIMIT_FIELD_W - CAPACITY_WIDTH_FIELD));

    // limit storage: secure bit, instance, partition
    logic [15:0] limit_mem [DEPTH];

    logic ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic alloc_done_q;
    logic alloc_allow_q;
    logic allow_w;
    logic [15:0] alloc_limit;

    pcc_sel_type sel_w;
    logic [IW-1:0] inst_w;
    logic sel_ok;
    logic [AW-1:0] acc_idx;
    logic [IW-1:0] ainst_w;
    logic a_ok;
    logic [AW-1:0] alloc_idx;
    logic [31:0] pri_sec [NUM_INST];
    logic [31:0] pri_ns [NUM_INST];

    // each page sees its own partition selector
    assign sel_w = req_i.secure ? sel_sec_i : sel_ns_i;

    // without instance selection the instance field plays no part
    assign inst_w = INST_SEL_PRESENT ? sel_w.inst[IW-1:0] : '0;
    // selections beyond the implemented range address no limit entry
    assign sel_ok = (32'(sel_w.part) < NUM_PART)
        && (!INST_SEL_PRESENT || (32'(sel_w.inst) < NUM_INST));
    assign acc_idx = {req_i.secure, inst_w, sel_w.part[PW-1:0]};

    assign ainst_w = INST_SEL_PRESENT ? alloc_i.inst[IW-1:0] : '0;
    assign a_ok = (32'(alloc_i.part) < NUM_PART)
        && (!INST_SEL_PRESENT || (32'(alloc_i.inst) < NUM_INST));
    assign alloc_idx = {alloc_i.secure, ainst_w, alloc_i.part[PW-1:0]};

    // priority identification images per instance and per page
    generate
        for (genvar i = 0; i < NUM_INST; i++) begin : g_pri
            // width is 0 when the field is absent, else 1 to 16
            logic has_int;
            logic has_int_s;
            logic has_ds;
            assign has_int = (INT_PRI_WD[i] != 6'h00) && (INT_PRI_WD[i] <= PCC_PRI_WD_MAX);
            assign has_int_s = (INT_PRI_WD_SEC[i] != 6'h00)
                && (INT_PRI_WD_SEC[i] <= PCC_PRI_WD_MAX);
            assign has_ds = (DS_PRI_WD[i] != 6'h00) && (DS_PRI_WD[i] <= PCC_PRI_WD_MAX);
            assign pri_ns[i] = {6'h00, has_ds ? DS_PRI_WD[i] : 6'h00, 2'b00,
                DS_PRI_ZERO_LOW[i], has_ds, 6'h00, has_int ? INT_PRI_WD[i] : 6'h00,
                2'b00, INT_PRI_ZERO_LOW[i], has_int} & PCC_PRI_FIELD_MASK;
            // separate secure copy; identical to the other when parameters agree
            assign pri_sec[i] = {6'h00, has_ds ? DS_PRI_WD[i] : 6'h00, 2'b00,
                DS_PRI_ZERO_LOW[i], has_ds, 6'h00,
                has_int_s ? INT_PRI_WD_SEC[i] : 6'h00,
                2'b00, INT_PRI_ZERO_LOW[i], has_int_s} & PCC_PRI_FIELD_MASK;
        end
    endgenerate

    // read mux: unmapped and refused locations read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (req_i.offset)
            PCC_OFF_PRI_ID: begin
                // both pages, following the selected instance
                if (req_i.secure) begin
                    rdata_d = pri_sec[inst_w];
                end else begin
                    rdata_d = pri_ns[inst_w];
                end
            end
            PCC_OFF_SECURE_ID: begin
                // only through the secure page, and only with a secure map
                if (req_i.secure && SECURE_MAP) begin
                    rdata_d[PCC_SID_PART_LSB +: PCC_SID_PART_W] = SECURE_PART_LIMIT;
                    rdata_d[PCC_SID_PMG_LSB +: PCC_SID_PMG_W] = SECURE_PMG_LIMIT;
                end
            end
            PCC_OFF_CAPACITY_LIMIT_FIELD: begin
                // absent capacity partitioning leaves the location reserved
                if (CAP_PART_PRESENT && sel_ok && (req_i.secure ? SECURE_MAP : 1'b1)) begin
                    rdata_d[15:0] = limit_mem[acc_idx] & CAPACITY_LIMIT_FIELD_MASK;
                end
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    // limit storage: stores only reach implemented bits of the low half
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int k = 0; k < DEPTH; k++) begin
                limit_mem[k] <= PCC_CAPACITY_LIMIT_FIELD_RESET & CAPACITY_LIMIT_FIELD_MASK;
            end
        end else if (req_i.valid && req_i.write && (req_i.offset == PCC_OFF_CAPACITY_LIMIT_FIELD)
                && CAP_PART_PRESENT && sel_ok
                && (req_i.secure ? SECURE_MAP : 1'b1)) begin
            // upper half and unimplemented low bits are dropped
            limit_mem[acc_idx] <= req_i.wdata[15:0] & CAPACITY_LIMIT_FIELD_MASK;
        end
    end

    // every load or store gets a one-cycle answer the cycle after
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q <= req_i.valid;
            // stores and idle cycles return zero so the bus stays quiet
            rdata_q <= (req_i.valid && !req_i.write) ? rdata_d : 32'h0000_0000;
        end
    end

    // the identifier used for the lookup is the one the allocation request carries; with
    // narrowing that is the internal identifier, which this slice trusts
    assign alloc_limit = (a_ok && CAP_PART_PRESENT) ? (limit_mem[alloc_idx] & CAPACITY_LIMIT_FIELD_MASK)
        : 16'hffff;

    pcc_cap_check #(
        .W(PCC_CAPACITY_LIMIT_FIELD_W)
    ) u_check (
        .limit_i(alloc_limit),
        .occupancy_i(alloc_i.occupancy),
        .allow_o(allow_w)
    );

    // allocation verdict registered one cycle after the request
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alloc_done_q <= 1'b0;
            alloc_allow_q <= 1'b0;
        end else begin
            alloc_done_q <= alloc_i.valid;
            alloc_allow_q <= alloc_i.valid && allow_w;
        end
    end

    assign ack_o = ack_q;
    assign rdata_o = rdata_q;
    assign alloc_done_o = alloc_done_q;
    assign alloc_allow_o = alloc_allow_q;
endmodule

/* File: pcc_pkg.sv */
// constants and carrier types for the partition cache capacity register slice
package pcc_pkg;

    // register offsets within a feature-page frame
    localparam logic [11:0] PCC_OFF_SECURE_ID = 12'h008;
    localparam logic [11:0] PCC_OFF_PRI_ID = 12'h048;
    localparam logic [11:0] PCC_OFF_CAPACITY_LIMIT_FIELD = 12'h108;

    // secure identification fields
    localparam int PCC_SID_PART_LSB = 0;
    localparam int PCC_SID_PART_W = 16;
    localparam int PCC_SID_PMG_LSB = 16;
    localparam int PCC_SID_PMG_W = 8;

    // priority identification fields
    localparam int PCC_PRI_INTWD_LSB = 4;
    localparam int PCC_PRI_DSWD_LSB = 20;
    localparam int PCC_PRI_WD_W = 6;
    localparam logic [5:0] PCC_PRI_WD_MAX = 6'h10;
    // bits that carry fields; all others are reserved and read zero
    localparam logic [31:0] PCC_PRI_FIELD_MASK = 32'h03_f3_03_f3;

    // capacity limit field
    localparam int PCC_CAPACITY_LIMIT_FIELD_W = 16;
    localparam logic [15:0] PCC_CAPACITY_LIMIT_FIELD_RESET = 16'hffff;

    // widths carried by the request structs
    localparam int PCC_OFF_W = 12;
    localparam int PCC_INST_W = 4;
    localparam int PCC_PART_W = 16;

    // one load or store from software into either feature page
    typedef struct packed {
        logic valid;
        logic write;
        logic secure;
        logic [PCC_OFF_W-1:0] offset;
        logic [31:0] wdata;
    } pcc_reg_req_type;

    // partition selector as currently programmed in each security state
    typedef struct packed {
        logic [PCC_INST_W-1:0] inst;
        logic [PCC_PART_W-1:0] part;
        logic internal;
    } pcc_sel_type;

    // allocation request from the cache to be checked against the limit
    typedef struct packed {
        logic valid;
        logic secure;
        logic [PCC_INST_W-1:0] inst;
        logic [PCC_PART_W-1:0] part;
        logic [PCC_CAPACITY_LIMIT_FIELD_W-1:0] occupancy;
    } pcc_alloc_req_type;

endpackage

/* File: pcc_cap_check.sv */
// comparison of a partition's occupancy fraction against its capacity limit
module pcc_cap_check #(
    parameter int W = 16
) (
    input wire logic [W-1:0] limit_i,
    input wire logic [W-1:0] occupancy_i,
    output logic allow_o
);
    // both are fractions below one with the point above the msb, so a plain
    // unsigned compare is enough; equal already means the limit is reached
    assign allow_o = (occupancy_i < limit_i);
endmodule

/* File: pcc_regs_sva.sv */
// checker for the register and allocation ports of pcc_regs
module pcc_regs_sva
    import pcc_pkg::*;
#(
    parameter int CAPACITY_WIDTH_FIELD = 16
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire pcc_pkg::pcc_reg_req_type req_i,
    input wire pcc_pkg::pcc_alloc_req_type alloc_i,
    input wire logic ack_o,
    input wire logic [31:0] rdata_o,
    input wire logic alloc_done_o,
    input wire logic alloc_allow_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // loads taken this edge; low_mask covers the limit bits that do not exist
    wire logic rd_v = req_i.valid && !req_i.write;
    wire logic [15:0] low_mask = 16'hffff >> CAPACITY_WIDTH_FIELD;
    ack_follows_a: assert property (req_i.valid |=> ack_o)
        else $error("no ack after request");
    ack_spurious_a: assert property (!req_i.valid |=> !ack_o)
        else $error("ack without request");
    rdata_idle_a: assert property (!ack_o |-> rdata_o == 32'h0)
        else $error("read data outside ack");
    store_quiet_a: assert property (req_i.valid && req_i.write |=> rdata_o == 32'h0)
        else $error("store returned data");
    pri_fields_a: assert property (rd_v && req_i.offset == PCC_OFF_PRI_ID
        |=> (rdata_o & ~PCC_PRI_FIELD_MASK) == 32'h0) else $error("priority reserved bits set");
    sid_page_a: assert property (rd_v && req_i.offset == PCC_OFF_SECURE_ID && !req_i.secure
        |=> rdata_o == 32'h0) else $error("secure id seen from nonsecure page");
    sid_upper_a: assert property (rd_v && req_i.offset == PCC_OFF_SECURE_ID
        |=> rdata_o[31:24] == 8'h0) else $error("secure id upper bits set");
    capacity_limit_field_bits_a: assert property (rd_v && req_i.offset == PCC_OFF_CAPACITY_LIMIT_FIELD
        |=> rdata_o[31:16] == 16'h0 && (rdata_o[15:0] & low_mask) == 16'h0)
        else $error("limit holds bits that do not exist");
    alloc_pulse_a: assert property (alloc_i.valid |=> alloc_done_o)
        else $error("allocation not answered");
    alloc_idle_a: assert property (!alloc_i.valid |=> !alloc_done_o && !alloc_allow_o)
        else $error("allocation answer without request");
    full_deny_a: assert property (alloc_i.valid && alloc_i.occupancy == 16'hffff
        |=> !alloc_allow_o) else $error("full occupancy allowed");
endmodule

/* File: pcc_regs_tb.sv */
// self-checking bench for pcc_regs against a model of the limit table
module pcc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pcc_pkg::*;
    localparam int CW = 12;
    logic clock_i = 1'b0;
    logic arst_n_i = 1'b0;
    pcc_reg_req_type req_i = '0;
    pcc_sel_type sel_sec_i = '0;
    pcc_sel_type sel_ns_i = '0;
    pcc_alloc_req_type alloc_i = '0;
    logic ack_o, alloc_done_o, alloc_allow_o;
    logic [31:0] rdata_o;
    logic [31:0] st = 32'd24361;
    logic [15:0] lim [int];
    logic [11:0] offs [4] = '{PCC_OFF_SECURE_ID, PCC_OFF_PRI_ID, PCC_OFF_CAPACITY_LIMIT_FIELD, 12'h0fc};
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    // instances, and the two pages of instance 1, get differing internal widths so the selection is visible
    pcc_regs #(.CAPACITY_WIDTH_FIELD(CW), .INT_PRI_WD({6'h08, 6'h04}), .INT_PRI_WD_SEC({6'h10, 6'h04}))
        pcc_regs_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .req_i(req_i), .sel_sec_i(sel_sec_i), .sel_ns_i(sel_ns_i), .alloc_i(alloc_i),
        .ack_o(ack_o), .rdata_o(rdata_o), .alloc_done_o(alloc_done_o),
        .alloc_allow_o(alloc_allow_o));
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction
    // unwritten limits hold the reset value cut to the top CW bits
    function automatic logic [15:0] lim_of(int k);
        return lim.exists(k) ? lim[k] : 16'hfff0;
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // clock and a ceiling well above the 600 request cycles
    initial forever #20 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    // one load or store and one allocation every cycle, back to back
    initial begin
        logic [31:0] r, wd, ex;
        logic [15:0] pt, occ, al;
        logic [11:0] off;
        logic [3:0] in;
        logic w, s, ok;
        int k;
        repeat (3) @(posedge clock_i);
        #1 arst_n_i = 1'b1;
        for (int i = 0; i < 600; i++) begin
            if (i == 300) begin // a second reset restores every limit
                arst_n_i = 1'b0;
                req_i.valid = 1'b0;
                alloc_i.valid = 1'b0;
                lim.delete();
                @(posedge clock_i);
                #1 arst_n_i = 1'b1;
            end
            r = rnd();
            wd = rnd();
            w = r[0];
            s = r[1];
            in = (r[11:10] == 2'b11) ? 4'h2 : {3'h0, r[2]};
            pt = (r[9:8] == 2'b11) ? 16'h0010 : {12'h0, r[7:4]};
            off = offs[r[13:12]];
            ok = in < 4'h2 && pt < 16'h0010;
            k = {s, in, pt};
            al = ok ? lim_of({r[15], in, pt}) : 16'hffff;
            occ = r[14] ? al : wd[15:0];
            ex = 32'h0;
            if (!w && off == PCC_OFF_PRI_ID) ex = 32'h0041_0041;
            if (!w && off == PCC_OFF_PRI_ID && in == 4'h1) ex[15:0] = s ? 16'h0101 : 16'h0081;
            if (!w && off == PCC_OFF_SECURE_ID && s) ex = 32'h000f_000f;
            if (!w && off == PCC_OFF_CAPACITY_LIMIT_FIELD && ok) ex = {16'h0, lim_of(k)};
            if (w && off == PCC_OFF_CAPACITY_LIMIT_FIELD && ok) lim[k] = wd[15:0] & 16'hfff0;
            req_i = '{valid: 1'b1, write: w, secure: s, offset: off, wdata: wd};
            // narrowing is absent here, so the internal flag stays clear on both pages
            sel_sec_i = s ? {in, pt, 1'b0} : {~in, ~pt, 1'b0};
            sel_ns_i = s ? {~in, ~pt, 1'b0} : {in, pt, 1'b0};
            alloc_i = '{valid: 1'b1, secure: r[15], inst: in, part: pt, occupancy: occ};
            @(posedge clock_i);
            #1;
            check("ack", 32'h1, ack_o);
            check("rdata", ex, rdata_o);
            check("alloc_done", 32'h1, alloc_done_o);
            check("alloc_allow", occ < al, alloc_allow_o);
        end
        summarize();
    end
endmodule
bind pcc_regs pcc_regs_sva #(.CAPACITY_WIDTH_FIELD(CAPACITY_WIDTH_FIELD)) pcc_regs_sva_inst (.clock_i(clock_i),
    .arst_n_i(arst_n_i), .req_i(req_i), .alloc_i(alloc_i), .ack_o(ack_o),
    .rdata_o(rdata_o), .alloc_done_o(alloc_done_o), .alloc_allow_o(alloc_allow_o));
